// *** hdl/sdc_ctrl.sv ***
// Sigma-delta converter control: APB registers, modulator timing, result and event
//
// The APB register port was left to the implementer.
`include "sdc_regs.svh"
`default_nettype none
module sdc_ctrl #(
  parameter int unsigned ADDR_W = 18,
  parameter int unsigned DIV    = `SDC_MOD_DIV
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // APB slave
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Modulator front end
  input  wire logic                  mod_bit,
  output var  logic                  mod_clk,
  output var  logic                  mod_run,
  output var  logic                  dither_disable,
  output var  logic [`SDC_SRC_CNT-1:0] src_onehot,
  output var  logic                  vref_out_en,
  // Event controller
  output var  logic                  conv_done_evt,
  output var  logic                  event_irq
);
  import sdc_pkg::*;

  localparam int unsigned HALF = DIV / 2;
  // Named copy of the reset word, since a literal cannot be bit-selected
  localparam logic [15:0] SETUP_RST = `SDC_SETUP_RST;

  // Setup register
  logic      cfg_en;
  sdc_rate_t cfg_rate;
  sdc_sel_t  cfg_sel;
  logic      next_en;
  // Event registers
  logic      evt_flag;
  logic      evt_mask;
  // Result
  logic [15:0] sample_result;
  // Control
  sdc_state_t state;
  sdc_state_t next_state;
  sdc_rate_t  rate_run;
  logic [15:0] div_cnt;
  logic [15:0] next_div;
  logic       tick;
  logic       restart;
  logic       bit_s1;
  logic       bit_s2;
  logic       dec_done;
  logic [15:0] dec_result;
  // Bus decode
  logic       setup;
  logic       hit_sample;
  logic       hit_setup;
  logic       hit_flag;
  logic       hit_mask;
  logic       hit_any;
  logic       wr;
  logic [31:0] rd_mux;
  logic [15:0] setup_view;

  // Bus decode
  always_comb begin
    setup      = psel && !penable;
    hit_sample = paddr == ADDR_W'({`SDC_IDX_SAMPLE, 2'b00});
    hit_setup  = paddr == ADDR_W'({`SDC_IDX_SETUP, 2'b00});
    hit_flag   = paddr == ADDR_W'({`SDC_IDX_EVT_FLAG, 2'b00});
    hit_mask   = paddr == ADDR_W'({`SDC_IDX_EVT_MASK, 2'b00});
    hit_any    = hit_sample || hit_setup || hit_flag || hit_mask;
    wr         = psel && penable && pready && pwrite && hit_any;
  end

  always_comb begin
    setup_view                               = 16'h0000;
    setup_view[`SDC_EN_BIT]                  = cfg_en;
    setup_view[`SDC_DITH_BIT]                = dither_disable;
    setup_view[`SDC_SEL_MSB:`SDC_SEL_LSB]    = cfg_sel;
    setup_view[`SDC_RATE_MSB:`SDC_RATE_LSB]  = cfg_rate;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_sample) begin
      rd_mux = {16'h0000, sample_result};
    end else if (hit_setup) begin
      rd_mux = {16'h0000, setup_view};
    end else if (hit_flag) begin
      rd_mux[`SDC_EVT_BIT] = evt_flag;
    end else if (hit_mask) begin
      rd_mux[`SDC_EVT_BIT] = evt_mask;
    end
  end

  // Answer one cycle after setup, read data captured at setup
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= setup && !hit_any;
    end
  end

  always_comb begin
    next_en = cfg_en;
    if (wr && hit_setup && pstrb[0]) begin
      next_en = pwdata[`SDC_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_en         <= SETUP_RST[`SDC_EN_BIT];
      dither_disable <= SETUP_RST[`SDC_DITH_BIT];
      cfg_sel        <= SETUP_RST[`SDC_SEL_MSB:`SDC_SEL_LSB];
      cfg_rate       <= SETUP_RST[`SDC_RATE_MSB:`SDC_RATE_LSB];
      vref_out_en    <= 1'b0;
    end else begin
      cfg_en      <= next_en;
      vref_out_en <= next_en;
      if (wr && hit_setup && pstrb[0]) begin
        dither_disable <= pwdata[`SDC_DITH_BIT];
      end
      if (wr && hit_setup && pstrb[1]) begin
        cfg_sel  <= pwdata[`SDC_SEL_MSB:`SDC_SEL_LSB];
        cfg_rate <= pwdata[`SDC_RATE_MSB:`SDC_RATE_LSB];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_onehot <= '0;
    end else begin
      src_onehot <= '0;
      case (sdc_src_t'(cfg_sel))
        SDC_SRC_SE0, SDC_SRC_SE1, SDC_SRC_SE2, SDC_SRC_SE3,
        SDC_SRC_PADS4, SDC_SRC_CORE2, SDC_SRC_GND, SDC_SRC_VREF,
        SDC_SRC_DIFF0, SDC_SRC_DIFF1: begin
          src_onehot[cfg_sel] <= 1'b1;
        end
        default: begin
          src_onehot <= '0;
        end
      endcase
    end
  end

  always_comb begin
    case (state)
      SDC_ST_IDLE: next_state = cfg_en ? SDC_ST_RUN : SDC_ST_IDLE;
      SDC_ST_RUN:  next_state = cfg_en ? SDC_ST_RUN : SDC_ST_IDLE;
      default:     next_state = SDC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state   <= SDC_ST_IDLE;
      mod_run <= 1'b0;
    end else begin
      state   <= next_state;
      mod_run <= next_state == SDC_ST_RUN;
    end
  end

  // Rate is taken per conversion so a change mid-run never splits one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rate_run <= '0;
    end else if (state != SDC_ST_RUN || dec_done) begin
      rate_run <= cfg_rate;
    end
  end

  always_comb begin
    restart  = state != SDC_ST_RUN;
    tick     = !restart && (div_cnt == 16'(DIV - 1));
    next_div = (restart || tick) ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 16'h0000;
      mod_clk <= 1'b0;
    end else begin
      div_cnt <= next_div;
      mod_clk <= (next_state == SDC_ST_RUN) && (next_div < 16'(HALF));
    end
  end

  // Modulator output is asynchronous to this clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
    end else begin
      bit_s1 <= mod_bit;
      bit_s2 <= bit_s1;
    end
  end

  sdc_decim #(
    .CNT_W (`SDC_CNT_W)
  ) u_decim (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .restart (restart),
    .tick    (tick),
    .bit_in  (bit_s2),
    .rate    (rate_run),
    .done    (dec_done),
    .result  (dec_result)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sample_result <= `SDC_SAMPLE_RST;
      conv_done_evt <= 1'b0;
    end else begin
      conv_done_evt <= dec_done && state == SDC_ST_RUN;
      if (dec_done && state == SDC_ST_RUN) begin
        sample_result <= dec_result;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evt_flag <= 1'b0;
      evt_mask <= 1'b0;
      event_irq <= 1'b0;
    end else begin
      if (conv_done_evt) begin
        evt_flag <= 1'b1;
      end else if (wr && hit_flag && pstrb[0] && pwdata[`SDC_EVT_BIT]) begin
        evt_flag <= 1'b0;
      end
      if (wr && hit_mask && pstrb[0]) begin
        evt_mask <= pwdata[`SDC_EVT_BIT];
      end
      event_irq <= evt_flag && evt_mask;
    end
  end

  // Helpers for checks
  logic        mclk_d;
  logic [15:0] gap;
  logic        gap_seen;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mclk_d   <= 1'b0;
      gap      <= 16'h0000;
      gap_seen <= 1'b0;
    end else begin
      mclk_d <= mod_clk;
      if (!mod_run) begin
        gap      <= 16'h0000;
        gap_seen <= 1'b0;
      end else if (mod_clk && !mclk_d) begin
        gap      <= 16'h0001;
        gap_seen <= 1'b1;
      end else begin
        gap <= gap + 16'h0001;
      end
    end
  end

  property p_mod_period;
    @(posedge clk_sys) disable iff (!rst_b)
    (mod_run && mod_clk && !mclk_d && gap_seen) |-> (gap == 16'(DIV));
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("modulator clock period wrong");

  property p_start;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == SDC_ST_IDLE && cfg_en) |=> (state == SDC_ST_RUN) ##1 mod_run;
  endproperty
  a_start: assert property (p_start) else $error("conversion did not start");

  property p_evt_run;
    @(posedge clk_sys) disable iff (!rst_b)
    conv_done_evt |-> $past(state) == SDC_ST_RUN;
  endproperty
  a_evt_run: assert property (p_evt_run) else $error("event while idle");

  property p_evt_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
    conv_done_evt |=> !conv_done_evt;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than one cycle");

  property p_result;
    @(posedge clk_sys) disable iff (!rst_b)
    (dec_done && state == SDC_ST_RUN) |=> conv_done_evt && sample_result == $past(dec_result);
  endproperty
  a_result: assert property (p_result) else $error("result not loaded with event");

  property p_flag_set;
    @(posedge clk_sys) disable iff (!rst_b)
    conv_done_evt |=> evt_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

  property p_flag_clr;
    @(posedge clk_sys) disable iff (!rst_b)
    (wr && hit_flag && pstrb[0] && pwdata[`SDC_EVT_BIT] && !conv_done_evt) |=> !evt_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_irq_mask;
    @(posedge clk_sys) disable iff (!rst_b)
    !evt_mask |=> !event_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");

  property p_vref;
    @(posedge clk_sys) disable iff (!rst_b)
    !cfg_en |-> !vref_out_en;
  endproperty
  a_vref: assert property (p_vref) else $error("reference out while disabled");
endmodule // sdc_ctrl
`default_nettype wire

// *** hdl/sdc_regs.svh ***
// Register map, field positions and timing constants of the sigma-delta converter control
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// Register indices; byte address is four times the index
`define SDC_IDX_SAMPLE   16'h4900
`define SDC_IDX_SETUP    16'h4902
`define SDC_IDX_EVT_FLAG 16'h4908
`define SDC_IDX_EVT_MASK 16'h490A

// Setup register fields, then the event bit of the flag and mask registers
`define SDC_EN_BIT       0
`define SDC_DITH_BIT     1
`define SDC_SEL_LSB      8
`define SDC_SEL_MSB      11
`define SDC_RATE_LSB     12
`define SDC_RATE_MSB     14
`define SDC_EVT_BIT      0

// Reset values
`define SDC_SETUP_RST    16'h0000
`define SDC_SAMPLE_RST   16'h0000

// Timing and resolution
`define SDC_CLK_HZ       250000000
`define SDC_MOD_HZ       1000000
`define SDC_MOD_DIV      (`SDC_CLK_HZ / `SDC_MOD_HZ)
`define SDC_BASE_US      32
`define SDC_BASE_SAMPLES (`SDC_BASE_US * `SDC_MOD_HZ / 1000000)
`define SDC_MIN_BITS     5
`define SDC_LJ_SHIFT     11
`define SDC_CNT_W        13
`define SDC_SRC_CNT      11

`endif

// *** hdl/sdc_pkg.sv ***
// Types shared by the sigma-delta converter control
`default_nettype none
package sdc_pkg;
  typedef logic [2:0] sdc_rate_t;
  typedef logic [3:0] sdc_sel_t;

  typedef enum logic [1:0] {
    SDC_ST_IDLE = 2'b01,
    SDC_ST_RUN  = 2'b10
  } sdc_state_t;

  typedef enum logic [3:0] {
    SDC_SRC_SE0   = 4'h0,
    SDC_SRC_SE1   = 4'h1,
    SDC_SRC_SE2   = 4'h2,
    SDC_SRC_SE3   = 4'h3,
    SDC_SRC_PADS4 = 4'h4,
    SDC_SRC_CORE2 = 4'h5,
    SDC_SRC_RSVD  = 4'h6,
    SDC_SRC_GND   = 4'h7,
    SDC_SRC_VREF  = 4'h8,
    SDC_SRC_DIFF0 = 4'h9,
    SDC_SRC_DIFF1 = 4'hA
  } sdc_src_t;
endpackage
`default_nettype wire

// *** hdl/sdc_decim.sv ***
// Decimator: counts modulator ones over one conversion and left-justifies the result
`include "sdc_regs.svh"
`default_nettype none
module sdc_decim #(
  parameter int unsigned CNT_W = `SDC_CNT_W
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Control
  input  wire logic              restart,
  input  wire logic              tick,
  input  wire logic              bit_in,
  input  wire sdc_pkg::sdc_rate_t rate,
  // Result
  output var  logic              done,
  output var  logic [15:0]       result
);
  import sdc_pkg::*;

  logic [CNT_W-1:0] samp_cnt;
  logic [CNT_W-1:0] ones_cnt;
  logic [CNT_W-1:0] last_samp;
  logic [CNT_W-1:0] total;
  logic [CNT_W-1:0] sat;
  logic [15:0]      next_result;
  logic             at_end;

  always_comb begin
    last_samp   = CNT_W'((CNT_W'(`SDC_BASE_SAMPLES) << rate) - CNT_W'(1));
    total       = ones_cnt + CNT_W'(bit_in);
    sat         = (total > last_samp) ? last_samp : total;
    next_result = 16'(sat) << (4'(`SDC_LJ_SHIFT) - {1'b0, rate});
    at_end      = tick && !restart && (samp_cnt == last_samp);
  end

  // All-ones input would need one more bit than the field holds, hence the clamp
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      samp_cnt <= '0;
      ones_cnt <= '0;
    end else if (restart || at_end) begin
      samp_cnt <= '0;
      ones_cnt <= '0;
    end else if (tick) begin
      samp_cnt <= samp_cnt + CNT_W'(1);
      ones_cnt <= total;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      done   <= 1'b0;
      result <= `SDC_SAMPLE_RST;
    end else begin
      done <= at_end;
      if (at_end) begin
        result <= next_result;
      end
    end
  end

  // Helpers for checks
  sdc_rate_t        res_rate;
  logic [CNT_W-1:0] span;
  logic             span_seen;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      res_rate  <= '0;
      span      <= '0;
      span_seen <= 1'b0;
    end else if (restart) begin
      span      <= '0;
      span_seen <= 1'b0;
    end else begin
      if (at_end) begin
        res_rate  <= rate;
        span      <= '0;
        span_seen <= 1'b1;
      end else if (tick) begin
        span <= span + CNT_W'(1);
      end
    end
  end

  property p_lj_result;
    @(posedge clk_sys) disable iff (!rst_b)
    done |-> ((result << (4'(res_rate) + 4'(`SDC_MIN_BITS))) == 16'h0000);
  endproperty
  a_lj_result: assert property (p_lj_result) else $error("result low bits not zero");

  property p_conv_len;
    @(posedge clk_sys) disable iff (!rst_b)
    (at_end && span_seen) |-> (span == last_samp);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
endmodule // sdc_decim
`default_nettype wire

// *** verif/sdc_mod_model.sv ***
// Behavioural modulator and input multiplexer facing the converter control
`default_nettype none
module sdc_mod_model #(
  parameter logic [10:0] HIGH_MASK = 11'h715
) (
  // Control from the block
  input  wire logic        clk_sys,
  input  wire logic        mod_clk,
  input  wire logic        mod_run,
  input  wire logic        dither_disable,
  input  wire logic [10:0] src_onehot,
  // Bitstream to the block
  output var  logic        mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  logic mod_clk_q = 1'b0;

  initial mod_bit = 1'b0;

  // one bit per period
  // Selected source gives a constant density so results are exact; dither is not modelled
  always @(posedge clk_sys) begin
    mod_clk_q <= mod_clk;
    if (!mod_run) begin
      mod_bit <= ~mod_bit;
    end else if (mod_clk && !mod_clk_q) begin
      mod_bit <= |(src_onehot & HIGH_MASK);
    end
  end
endmodule // sdc_mod_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the sigma-delta converter control
`include "sdc_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdc_pkg::*;

  localparam int unsigned DIV   = 4;
  localparam logic [17:0] A_SMP = 18'(`SDC_IDX_SAMPLE * 4);
  localparam logic [17:0] A_CFG = 18'(`SDC_IDX_SETUP * 4);
  localparam logic [17:0] A_FLG = 18'(`SDC_IDX_EVT_FLAG * 4);
  localparam logic [17:0] A_MSK = 18'(`SDC_IDX_EVT_MASK * 4);
  localparam logic [17:0] A_BAD = 18'h12404;

  typedef struct {
    sdc_rate_t   rate;
    sdc_sel_t    src;
    logic        dith;
    logic [10:0] hot;
    logic [15:0] smp;
  } sdc_row_t;

  sdc_row_t rows [11] = '{
    '{3'h0, 4'h0, 1'b0, 11'h001, 16'hF800}, '{3'h1, 4'h1, 1'b1, 11'h002, 16'h0000},
    '{3'h2, 4'h2, 1'b0, 11'h004, 16'hFE00}, '{3'h3, 4'h3, 1'b1, 11'h008, 16'h0000},
    '{3'h4, 4'h4, 1'b0, 11'h010, 16'hFF80}, '{3'h5, 4'h5, 1'b1, 11'h020, 16'h0000},
    '{3'h6, 4'h6, 1'b0, 11'h000, 16'h0000}, '{3'h7, 4'h7, 1'b1, 11'h080, 16'h0000},
    '{3'h0, 4'h8, 1'b0, 11'h100, 16'hF800}, '{3'h1, 4'h9, 1'b1, 11'h200, 16'hFC00},
    '{3'h2, 4'hA, 1'b0, 11'h400, 16'hFE00}};

  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic [17:0] paddr   = 18'h0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready, pslverr, mod_bit, mod_clk, mod_run, dither_disable;
  logic [10:0] src_onehot;
  logic        vref_out_en, conv_done_evt, event_irq;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          checked   = 0;
  int          n;

  always #2 clk_sys = ~clk_sys;

  sdc_ctrl #(.ADDR_W(18), .DIV(DIV)) dut (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .mod_bit, .mod_clk, .mod_run, .dither_disable,
    .src_onehot, .vref_out_en, .conv_done_evt, .event_irq);

  sdc_mod_model #(.HIGH_MASK(11'h715)) model (.clk_sys, .mod_clk, .mod_run, .dither_disable,
    .src_onehot, .mod_bit);

  task automatic test_done();
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    chk("apb_wait", 32'h1, 32'(k));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  // Bounded wait for one completion pulse; cnt is the cycles it took
  task automatic wait_evt(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      cnt++;
    end while (conv_done_evt !== 1'b1 && cnt < lim);
    chk("evt_seen", 32'h1, 32'(conv_done_evt));
    @(posedge clk_sys);
    chk("evt_width", 32'h0, 32'(conv_done_evt));
  endtask

  initial begin
    #(90000 * 4);
    error_cnt++;
    test_done();
  end

  initial begin
    int lim;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("rst_vref", 32'h0, 32'(vref_out_en));
    chk("rst_run", 32'h0, 32'(mod_run));
    chk("rst_mclk", 32'h0, 32'(mod_clk));
    rd_chk("rst_sample", A_SMP, 32'h0);
    rd_chk("rst_setup", A_CFG, 32'h0);
    foreach (rows[i]) begin
      // Enable cleared around every change of source or rate
      apb(1'b1, A_CFG, {17'h0, rows[i].rate, rows[i].src, 6'h0, rows[i].dith, 1'b0});
      apb(1'b1, A_CFG, {17'h0, rows[i].rate, rows[i].src, 6'h0, rows[i].dith, 1'b1});
      lim = (32 << rows[i].rate) * DIV + 64;
      wait_evt(lim, n);
      wait_evt(lim, n);
      chk("conv_cycles", 32'((32 << rows[i].rate) * DIV), 32'(n + 1));
      rd_chk("flag_seen", A_FLG, 32'h1);
      apb(1'b1, A_FLG, 32'h1);
      rd_chk("sample", A_SMP, {16'h0, rows[i].smp});
      chk("onehot", {21'h0, rows[i].hot}, {21'h0, src_onehot});
      chk("dither", 32'(rows[i].dith), 32'(dither_disable));
      chk("vref_on", 32'h1, 32'(vref_out_en));
      apb(1'b1, A_CFG, {17'h0, rows[i].rate, rows[i].src, 6'h0, rows[i].dith, 1'b0});
    end
    // Enable set briefly here: too short for any conversion to finish
    apb(1'b1, A_CFG, 32'hFFFF_FFFF);
    rd_chk("setup_bits", A_CFG, 32'h0000_7F03);
    chk("onehot_bad", 32'h0, {21'h0, src_onehot});
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b1, A_SMP, 32'h0000_1234);
    rd_chk("sample_ro", A_SMP, 32'h0000_FE00);
    apb(1'b0, A_BAD, 32'h0);
    chk("bad_err", 32'h1, 32'(err));
    chk("bad_data", 32'h0, rd);
    // Abort in mid-conversion
    apb(1'b1, A_CFG, 32'h0000_3001);
    repeat (300) @(posedge clk_sys);
    apb(1'b1, A_CFG, 32'h0);
    n = 0;
    repeat (1200) begin
      @(posedge clk_sys);
      if (conv_done_evt === 1'b1) n++;
    end
    chk("abort_evt", 32'h0, 32'(n));
    chk("vref_off", 32'h0, 32'(vref_out_en));
    rd_chk("sample_hold", A_SMP, 32'h0000_FE00);
    // Flag was cleared in the loop; one completion with the mask off sets it again
    apb(1'b1, A_CFG, 32'h1);
    wait_evt(32 * DIV * 2 + 64, n);
    repeat (2) @(posedge clk_sys);
    chk("irq_masked", 32'h0, 32'(event_irq));
    apb(1'b1, A_CFG, 32'h0);
    rd_chk("flag_pend", A_FLG, 32'h1);
    apb(1'b1, A_MSK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq_on", 32'h1, 32'(event_irq));
    apb(1'b1, A_FLG, 32'h1);
    rd_chk("flag_w1c", A_FLG, 32'h0);
    chk("irq_clr", 32'h0, 32'(event_irq));
    apb(1'b1, A_CFG, 32'h1);
    wait_evt(32 * DIV * 2 + 64, n);
    repeat (2) @(posedge clk_sys);
    chk("irq_evt", 32'h1, 32'(event_irq));
    apb(1'b1, A_CFG, 32'h0);
    rd_chk("flag_set", A_FLG, 32'h1);
    apb(1'b1, A_MSK, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("irq_off", 32'h0, 32'(event_irq));
    test_done();
  end
endmodule // testbench
`default_nettype wire
